/* bzt_buzzer_model.sv */
// Purpose: Buzzer transducer model timing the tone pin
// Assumes: Pin sampled on the system clock
// Notes: Reports last high time, last period and cycles since an edge
`timescale 1ns/1ps
`default_nettype none

module bzt_buzzer_model
(
	input wire logic clk, // System clock
	input wire logic pin, // Tone pin
	output logic [15:0] hi_len, // Last high time
	output logic [15:0] per_len, // Last period
	output logic [15:0] idle // Cycles since edge
);
	logic prev = 1'h0;
	logic [15:0] hcnt = 16'h0000;
	logic [15:0] pcnt = 16'h0000;

	initial hi_len = 16'h0000;
	initial per_len = 16'h0000;
	initial idle = 16'h0000;

	always @(posedge clk)
	begin
		prev <= pin;
		idle <= (pin !== prev) ? 16'h0000 : idle + 16'h0001;
		hcnt <= (pin === 1'h1) ? hcnt + 16'h0001 : 16'h0000;
		if (pin === 1'h0 && prev === 1'h1)
			hi_len <= hcnt;
		if (pin === 1'h1 && prev === 1'h0)
		begin
			per_len <= pcnt;
			pcnt <= 16'h0001;
		end
		else
			pcnt <= pcnt + 16'h0001;
	end
endmodule : bzt_buzzer_model
`default_nettype wire

/* bzt_divider.sv */
// Purpose: Divider chain turning base ticks into low, burst and envelope ticks
// Assumes: base_tick is a one-cycle pulse at twice the oscillator rate
// Notes: All tick outputs are registered one-cycle pulses
`timescale 1ns/1ps
`default_nettype none

module bzt_divider
	import bzt_pkg::*;
#(
	parameter int DIV_W = $clog2(DIV_ENV_SLOW)
)
(
	input wire logic clk, // System clock
	input wire logic rst, // Synchronous reset
	input wire logic base_tick, // Base tick pulse
	output logic tick_low, // Half base rate pulse
	output logic tick_burst, // 256 Hz pulse
	output logic tick_fast, // 16 Hz pulse
	output logic tick_slow // 8 Hz pulse
);

	logic [DIV_W-1:0] count;

	// ----------------------------------------------------------------
	// Shared chain
	// ----------------------------------------------------------------
	always_ff @(posedge clk)
	begin
		if (rst)
			count <= '0;
		else if (base_tick)
			count <= count + 1'b1;
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			tick_low <= 1'b0;
			tick_burst <= 1'b0;
			tick_fast <= 1'b0;
			tick_slow <= 1'b0;
		end
		else
		begin
			tick_low <= base_tick && count[0];
			tick_burst <= base_tick && (&count[$clog2(DIV_BURST)-1:0]);
			tick_fast <= base_tick && (&count[$clog2(DIV_ENV_FAST)-1:0]);
			tick_slow <= base_tick && (&count[$clog2(DIV_ENV_SLOW)-1:0]);
		end
	end

endmodule : bzt_divider
`default_nettype wire

/* bzt_pkg.sv */
// Purpose: Shared constants and types of the buzzer tone generator
// Assumes: Low-frequency oscillator of 32768 Hz, system clock of 200 MHz
// Notes: Register word index times four gives the APB byte address
//
// Overview of operation
// - Output enable at 1 drives the generated tone waveform onto the pin.
// - Output enable at 0 holds the tone pin low except while a burst runs.
// - Tone divides the 32.768 kHz clock; three-bit code picks one of eight frequencies.
// - Duty code sets high fraction: 8/16..1/16 and 8/20..1/20 groups.
// - Third and fourth frequency pairs give 12/24..5/24 and 12/28..5/28; code 0 loudest.
// - With envelope and output enabled, envelope level replaces the software duty code.
// - Envelope enable at 1 applies duty stepping; at 0 no envelope.
// - Output start with envelope on begins at level 1, stepping toward level 8.
// - After reaching level 8 the envelope holds it while output continues.
// - Restart write during envelope output returns duty to level 1, then decay resumes.
// - Envelope steps every 62.5 ms when step select is 0, 125 ms when 1.
// - First step may come up to one whole step time early; tick runs freely.
// - Burst length select gives 125 ms at 1 and 31.25 ms at 0.
// - Burst trigger write starts tone output at the next 256 Hz tick.
// - Burst ends after its duration, aligned to the 256 Hz tick.
// - Trigger bit reads 1 while a burst runs, 0 when idle.
// - Stop write during a burst ends it early at the next 256 Hz tick.
// - Trigger during a burst restarts the full duration from the next tick.
// - Bursts never use the envelope; they use current frequency and duty codes.
// - While output enable is 1, burst triggers are ignored.
// - Restart write is ignored without envelope or without output; writing 0 does nothing.
// - Stop write is ignored unless a burst is in progress.
// - Restart, stop and unused bits always read 0.

package bzt_pkg;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam int APB_AW = 18;
	localparam logic [15:0] IDX_ENVELOPE_AND_OUTPUT_CONTROL = 16'hFF6C;
	localparam logic [15:0] IDX_SINGLE_BURST_CONTROL = 16'hFF6D;
	localparam logic [15:0] IDX_TONE_FREQUENCY_SELECT = 16'hFF6E;
	localparam logic [15:0] IDX_TONE_DUTY_SELECT = 16'hFF6F;
	localparam logic [APB_AW-1:0] ADDR_ENVELOPE_AND_OUTPUT_CONTROL = {IDX_ENVELOPE_AND_OUTPUT_CONTROL, 2'b00};
	localparam logic [APB_AW-1:0] ADDR_SINGLE_BURST_CONTROL = {IDX_SINGLE_BURST_CONTROL, 2'b00};
	localparam logic [APB_AW-1:0] ADDR_TONE_FREQUENCY_SELECT = {IDX_TONE_FREQUENCY_SELECT, 2'b00};
	localparam logic [APB_AW-1:0] ADDR_TONE_DUTY_SELECT = {IDX_TONE_DUTY_SELECT, 2'b00};

	// ----------------------------------------------------------------
	// Field positions and reset values
	// ----------------------------------------------------------------
	localparam int BIT_TONE_OUTPUT_ENABLE = 0;
	localparam int BIT_ENVELOPE_ENABLE = 1;
	localparam int BIT_ENVELOPE_RESTART = 2;
	localparam int BIT_ENVELOPE_STEP_TIME_SELECT = 3;
	localparam int BIT_SINGLE_BURST_LENGTH_SELECT = 0;
	localparam int BIT_SINGLE_BURST_TRIGGER = 1;
	localparam int BIT_SINGLE_BURST_STOP = 2;
	localparam int CODE_W = 3;
	localparam logic RST_CTRL_BIT = 1'b0;
	localparam logic [CODE_W-1:0] RST_FREQUENCY_CODE = 3'h0;
	localparam logic [CODE_W-1:0] RST_DUTY_CODE = 3'h0;
	localparam logic [CODE_W-1:0] DUTY_LEVEL_MAX = 3'h0;
	localparam logic [CODE_W-1:0] DUTY_LEVEL_MIN = 3'h7;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int LFO_HZ = 32768;
	localparam int BASE_HZ = 2 * LFO_HZ;
	localparam int TICK_BURST_HZ = 256;
	localparam int US_PER_S = 1000000;
	localparam int ENV_STEP_FAST_US = 62500;
	localparam int ENV_STEP_SLOW_US = 125000;
	localparam int BURST_SHORT_US = 31250;
	localparam int BURST_LONG_US = 125000;
	localparam int DIV_BURST = BASE_HZ / TICK_BURST_HZ;
	localparam int DIV_ENV_FAST = int'(longint'(ENV_STEP_FAST_US) * BASE_HZ / US_PER_S);
	localparam int DIV_ENV_SLOW = int'(longint'(ENV_STEP_SLOW_US) * BASE_HZ / US_PER_S);
	localparam int BURST_CNT_W = 6;
	localparam logic [BURST_CNT_W-1:0] BURST_SHORT_TICKS = BURST_CNT_W'(BURST_SHORT_US * TICK_BURST_HZ / US_PER_S);
	localparam logic [BURST_CNT_W-1:0] BURST_LONG_TICKS = BURST_CNT_W'(BURST_LONG_US * TICK_BURST_HZ / US_PER_S);

	// ----------------------------------------------------------------
	// Waveform shape
	// ----------------------------------------------------------------
	localparam int PHASE_W = 5;
	localparam logic [PHASE_W-1:0] PERIOD_BASE_TICKS = 5'h10;
	localparam logic [PHASE_W-1:0] HIGH_SHORT_TICKS = 5'h08;
	localparam logic [PHASE_W-1:0] HIGH_LONG_TICKS = 5'h0C;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		BURST_IDLE = 3'b001,
		BURST_ARMED = 3'b010,
		BURST_RUN = 3'b100
	} bzt_burst_type;

endpackage : bzt_pkg

/* bzt_tone.sv */
// Purpose: Buzzer tone generator with envelope and timed bursts behind APB
// Assumes: Oscillator input is asynchronous and slow against clk
// Notes: Tone runs freely, so enabling it may cut a period short
//
// Design decision made here: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module bzt_tone
	import bzt_pkg::*;
(
	input wire logic clk, // System clock
	input wire logic rst, // Synchronous reset
	input wire logic low_frequency_oscillator_clock, // Oscillator pin
	input wire logic [bzt_pkg::APB_AW-1:0] paddr, // APB address
	input wire logic psel, // APB select
	input wire logic penable, // APB enable
	input wire logic pwrite, // APB direction
	input wire logic [31:0] pwdata, // APB write data
	output logic [31:0] prdata, // APB read data
	output logic pready, // APB ready
	output logic pslverr, // APB error
	output logic tone_output_pin // Buzzer drive
);

	// ----------------------------------------------------------------
	// Oscillator synchroniser and base tick
	// ----------------------------------------------------------------
	logic osc_meta;
	logic osc_sync;
	logic osc_prev;
	logic base_tick;
	logic tick_low;
	logic tick_burst;
	logic tick_fast;
	logic tick_slow;

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			osc_meta <= 1'b0;
			osc_sync <= 1'b0;
			osc_prev <= 1'b0;
		end
		else
		begin
			osc_meta <= low_frequency_oscillator_clock;
			osc_sync <= osc_meta;
			osc_prev <= osc_sync;
		end
	end

	// Both oscillator edges give the base rate
	assign base_tick = osc_sync ^ osc_prev;

	bzt_divider u_divider (
		.clk(clk),
		.rst(rst),
		.base_tick(base_tick),
		.tick_low(tick_low),
		.tick_burst(tick_burst),
		.tick_fast(tick_fast),
		.tick_slow(tick_slow)
	);

	// ----------------------------------------------------------------
	// APB decode
	// ----------------------------------------------------------------
	logic hit_ctrl;
	logic hit_burst;
	logic hit_freq;
	logic hit_duty;
	logic mapped;
	logic wr_access;
	logic wr_ctrl;
	logic wr_burst;

	assign hit_ctrl = paddr == ADDR_ENVELOPE_AND_OUTPUT_CONTROL;
	assign hit_burst = paddr == ADDR_SINGLE_BURST_CONTROL;
	assign hit_freq = paddr == ADDR_TONE_FREQUENCY_SELECT;
	assign hit_duty = paddr == ADDR_TONE_DUTY_SELECT;
	assign mapped = hit_ctrl || hit_burst || hit_freq || hit_duty;
	assign wr_access = psel && penable && pwrite && mapped;
	assign wr_ctrl = wr_access && hit_ctrl;
	assign wr_burst = wr_access && hit_burst;
	assign pready = 1'b1;
	assign pslverr = psel && penable && !mapped;

	// ----------------------------------------------------------------
	// Software registers
	// ----------------------------------------------------------------
	logic tone_output_enable;
	logic envelope_enable;
	logic envelope_step_time_select;
	logic single_burst_length_select;
	logic [CODE_W-1:0] tone_frequency_code;
	logic [CODE_W-1:0] duty_level_code;

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			tone_output_enable <= RST_CTRL_BIT;
			envelope_enable <= RST_CTRL_BIT;
			envelope_step_time_select <= RST_CTRL_BIT;
		end
		else if (wr_ctrl)
		begin
			tone_output_enable <= pwdata[BIT_TONE_OUTPUT_ENABLE];
			envelope_enable <= pwdata[BIT_ENVELOPE_ENABLE];
			envelope_step_time_select <= pwdata[BIT_ENVELOPE_STEP_TIME_SELECT];
		end
	end

	always_ff @(posedge clk)
	begin
		if (rst)
			single_burst_length_select <= RST_CTRL_BIT;
		else if (wr_burst)
			single_burst_length_select <= pwdata[BIT_SINGLE_BURST_LENGTH_SELECT];
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			tone_frequency_code <= RST_FREQUENCY_CODE;
			duty_level_code <= RST_DUTY_CODE;
		end
		else if (wr_access)
		begin
			if (hit_freq)
				tone_frequency_code <= pwdata[CODE_W-1:0];
			if (hit_duty)
				duty_level_code <= pwdata[CODE_W-1:0];
		end
	end

	// ----------------------------------------------------------------
	// Digital envelope
	// ----------------------------------------------------------------
	logic [CODE_W-1:0] envelope_level;
	logic restart_wr;
	logic step_tick;

	// Restart needs envelope on and tone output running
	assign restart_wr = wr_ctrl && pwdata[BIT_ENVELOPE_RESTART] && envelope_enable && tone_output_enable;
	// Free-running tick, so the first step lands anywhere within one period
	assign step_tick = envelope_step_time_select ? tick_slow : tick_fast;

	always_ff @(posedge clk)
	begin
		if (rst || !tone_output_enable)
			envelope_level <= DUTY_LEVEL_MAX;
		else if (restart_wr)
			envelope_level <= DUTY_LEVEL_MAX;
		else if (envelope_enable && step_tick && envelope_level != DUTY_LEVEL_MIN)
			envelope_level <= envelope_level + 1'b1;
	end

	// ----------------------------------------------------------------
	// Waveform
	// ----------------------------------------------------------------
	logic [CODE_W-1:0] active_level;
	logic [PHASE_W-1:0] period_ticks;
	logic [PHASE_W-1:0] high_ticks;
	logic [PHASE_W-1:0] phase;
	logic wave_step;
	logic wave;

	// Burst only runs with output enable low, so it never sees the envelope
	assign active_level = (envelope_enable && tone_output_enable) ? envelope_level : duty_level_code;
	assign period_ticks = PERIOD_BASE_TICKS + {1'b0, tone_frequency_code[1:0], 2'b00};
	assign high_ticks = (tone_frequency_code[1] ? HIGH_LONG_TICKS : HIGH_SHORT_TICKS)
		- {2'b00, active_level};
	assign wave_step = tone_frequency_code[2] ? tick_low : base_tick;

	always_ff @(posedge clk)
	begin
		if (rst)
			phase <= '0;
		else if (wave_step)
		begin
			if (phase >= period_ticks - 1'b1)
				phase <= '0;
			else
				phase <= phase + 1'b1;
		end
	end

	always_ff @(posedge clk)
	begin
		if (rst)
			wave <= 1'b0;
		else
			wave <= phase < high_ticks;
	end

	// ----------------------------------------------------------------
	// Timed burst
	// ----------------------------------------------------------------
	bzt_burst_type burst_state;
	logic [BURST_CNT_W-1:0] burst_count;
	logic trigger_wr;
	logic stop_wr;
	logic retrig_pend;
	logic stop_pend;
	logic do_stop;
	logic do_retrig;
	logic burst_busy;

	assign burst_busy = burst_state != BURST_IDLE;
	assign trigger_wr = wr_burst && pwdata[BIT_SINGLE_BURST_TRIGGER] && !tone_output_enable;
	assign stop_wr = wr_burst && pwdata[BIT_SINGLE_BURST_STOP] && burst_busy;
	// Same-cycle writes act at once, so a tick never loses them
	assign do_stop = stop_pend || stop_wr;
	assign do_retrig = retrig_pend || trigger_wr;

	always_ff @(posedge clk)
	begin
		if (rst || tick_burst)
		begin
			retrig_pend <= 1'b0;
			stop_pend <= 1'b0;
		end
		else
		begin
			if (trigger_wr && burst_state == BURST_RUN)
				retrig_pend <= 1'b1;
			if (stop_wr)
				stop_pend <= 1'b1;
		end
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			burst_state <= BURST_IDLE;
			burst_count <= '0;
		end
		else
		begin
			case (burst_state)
				BURST_IDLE:
				begin
					if (trigger_wr)
						burst_state <= BURST_ARMED;
				end
				BURST_ARMED:
				begin
					if (tick_burst)
					begin
						if (do_stop)
							burst_state <= BURST_IDLE;
						else
						begin
							burst_state <= BURST_RUN;
							burst_count <= single_burst_length_select ? BURST_LONG_TICKS : BURST_SHORT_TICKS;
						end
					end
				end
				BURST_RUN:
				begin
					if (tick_burst)
					begin
						if (do_stop)
							burst_state <= BURST_IDLE;
						else if (do_retrig)
							burst_count <= single_burst_length_select ? BURST_LONG_TICKS : BURST_SHORT_TICKS;
						else if (burst_count == 1)
							burst_state <= BURST_IDLE;
						else
							burst_count <= burst_count - 1'b1;
					end
				end
				default:
				begin
					burst_state <= BURST_IDLE;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Pin drive
	// ----------------------------------------------------------------
	logic tone_on;

	assign tone_on = tone_output_enable || burst_state == BURST_RUN;

	always_ff @(posedge clk)
	begin
		if (rst)
			tone_output_pin <= 1'b0;
		else
			tone_output_pin <= tone_on && wave;
	end

	// ----------------------------------------------------------------
	// Read data, captured in the setup phase
	// ----------------------------------------------------------------
	always_ff @(posedge clk)
	begin
		if (rst)
			prdata <= '0;
		else if (psel && !penable && !pwrite)
		begin
			prdata <= '0;
			if (hit_ctrl)
				prdata[3:0] <= {envelope_step_time_select, 1'b0, envelope_enable, tone_output_enable};
			if (hit_burst)
				prdata[3:0] <= {2'b00, burst_busy, single_burst_length_select};
			if (hit_freq)
				prdata[CODE_W-1:0] <= tone_frequency_code;
			if (hit_duty)
				prdata[CODE_W-1:0] <= duty_level_code;
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	sequence seq_stop_seen;
		do_stop && burst_busy;
	endsequence

	sequence seq_burst_tick;
		tick_burst;
	endsequence

	AST_PIN_LOW_WHEN_OFF: assert property (@(posedge clk) disable iff (rst)
		!tone_on |=> !tone_output_pin)
		else $error("tone pin high while output is off");
	AST_PIN_FOLLOWS_WAVE: assert property (@(posedge clk) disable iff (rst)
		tone_output_enable |=> tone_output_pin == $past(wave))
		else $error("tone pin does not follow waveform");
	AST_PHASE_WRAP: assert property (@(posedge clk) disable iff (rst)
		wave_step && phase == period_ticks - 1'b1 |=> phase == 0)
		else $error("phase did not wrap at period end");
	AST_ENV_HOLD_MIN: assert property (@(posedge clk) disable iff (rst)
		tone_output_enable && envelope_level == DUTY_LEVEL_MIN && !restart_wr
		##1 tone_output_enable |-> envelope_level == DUTY_LEVEL_MIN)
		else $error("envelope left minimum level");
	AST_ENV_RESTART: assert property (@(posedge clk) disable iff (rst)
		restart_wr |=> envelope_level == DUTY_LEVEL_MAX)
		else $error("restart did not return level to maximum");
	AST_ENV_STEP_RATE: assert property (@(posedge clk) disable iff (rst)
		tone_output_enable && $past(tone_output_enable) && {1'b0, envelope_level} == $past(envelope_level) + 4'h1
		|-> $past(step_tick))
		else $error("envelope stepped without its tick");
	AST_TRIG_BLOCKED: assert property (@(posedge clk) disable iff (rst)
		burst_state == BURST_IDLE && tone_output_enable |=> burst_state == BURST_IDLE)
		else $error("burst started while output enabled");
	AST_START_ALIGNED: assert property (@(posedge clk) disable iff (rst)
		burst_state == BURST_ARMED && !tick_burst |=> burst_state == BURST_ARMED)
		else $error("burst started off the 256 Hz tick");
	AST_STOP_AT_TICK: assert property (@(posedge clk) disable iff (rst)
		seq_stop_seen ##0 seq_burst_tick |=> burst_state == BURST_IDLE)
		else $error("stop request did not end burst at tick");
	AST_STOP_IGNORED: assert property (@(posedge clk) disable iff (rst)
		burst_state == BURST_IDLE && !trigger_wr |=> burst_state == BURST_IDLE && !stop_pend)
		else $error("stop acted while idle");
	AST_BUSY_READ: assert property (@(posedge clk) disable iff (rst)
		psel && !penable && !pwrite && hit_burst |=> prdata[BIT_SINGLE_BURST_TRIGGER] == $past(burst_busy))
		else $error("busy readback wrong");
	AST_WO_READ_ZERO: assert property (@(posedge clk) disable iff (rst)
		prdata[31:4] == '0 && !(prdata[BIT_ENVELOPE_RESTART] && $past(hit_ctrl)))
		else $error("write-only or unused bits read nonzero");
	AST_BURST_LONG: assert property (@(posedge clk) disable iff (rst)
		burst_state == BURST_ARMED && tick_burst && !do_stop && single_burst_length_select
		|=> burst_count == BURST_LONG_TICKS)
		else $error("long burst length wrong");

endmodule : bzt_tone
`default_nettype wire

/* tb_top.sv */
// Purpose: Register level test of the tone generator
// Assumes: Oscillator pin toggles every 4 clocks
// Notes: Base tick 4 clocks, 256 Hz tick 1024 clocks
`timescale 1ns/1ps
`default_nettype none

module tb_top;
	import bzt_pkg::*;
	localparam logic [APB_AW-1:0] AC = ADDR_ENVELOPE_AND_OUTPUT_CONTROL;
	localparam logic [APB_AW-1:0] AB = ADDR_SINGLE_BURST_CONTROL;
	localparam logic [APB_AW-1:0] AF = ADDR_TONE_FREQUENCY_SELECT;
	localparam logic [APB_AW-1:0] AD = ADDR_TONE_DUTY_SELECT;
	logic clk = 1'h0;
	logic rst = 1'h1;
	logic osc = 1'h0;
	logic [APB_AW-1:0] paddr = '0;
	logic psel = 1'h0;
	logic penable = 1'h0;
	logic pwrite = 1'h0;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic pin;
	logic serr;
	logic [31:0] q;
	logic [15:0] hi;
	logic [15:0] per;
	logic [15:0] idle;
	int cyc = 0;
	int err_count = 0;
	int num_checks = 0;
	int s;
	int n;

	bzt_tone uut (.clk(clk), .rst(rst), .low_frequency_oscillator_clock(osc), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .tone_output_pin(pin));
	bzt_buzzer_model mdl (.clk(clk), .pin(pin), .hi_len(hi), .per_len(per), .idle(idle));

	initial forever #2.5 clk = ~clk;

	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (cyc % 4 == 3)
			osc <= ~osc;
	end

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			err_count++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	task automatic apb(input logic [APB_AW-1:0] a, input logic w, input logic [31:0] d);
		@(posedge clk);
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		psel <= 1'h1;
		@(posedge clk);
		penable <= 1'h1;
		do @(posedge clk); while (pready !== 1'h1);
		q = prdata;
		serr = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask : apb

	task automatic wr(input logic [APB_AW-1:0] a, input logic [31:0] d);
		apb(a, 1'h1, d);
	endtask : wr

	task automatic rd(input logic [APB_AW-1:0] a, input logic [31:0] e, input string nm);
		apb(a, 1'h0, 32'h0);
		chk(nm, q, e);
	endtask : rd

	task automatic burst(input logic [31:0] ctl, input int at, input logic [31:0] act, input int exp);
		int t0;
		wr(AB, ctl | 32'h2);
		rd(AB, ctl | 32'h2, "busy");
		for (n = 0; n < 2000 && pin !== 1'h1; n++) @(posedge clk);
		t0 = cyc;
		repeat (300) @(posedge clk);
		chk("burst_high", 32'(hi), 32'h14);
		repeat (at) @(posedge clk);
		if (act != 0)
			wr(AB, act);
		for (n = 0; n < 40000 && idle < 16'h0190; n++) @(posedge clk);
		s = cyc - int'(idle) - t0;
		chk("burst_len", 32'(s + 150 >= exp && s <= exp + 20), 32'h1);
		rd(AB, ctl, "idle");
	endtask : burst

	task automatic summarize();
		if (err_count == 0 && num_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : summarize

	initial
	begin
		#500000;
		err_count++;
		summarize();
	end

	initial
	begin
		repeat (3) @(posedge clk);
		rst <= 1'h0;
		for (int i = 0; i < 4; i++)
			rd(AC + APB_AW'(4 * i), 32'h0, "reg_reset");
		apb(AC - APB_AW'(4), 1'h0, 32'h0);
		chk("unmapped_data", q, 32'h0);
		chk("unmapped_err", 32'(serr), 32'h1);
		wr(AC, 32'hC);
		rd(AC, 32'h8, "ctrl_readback");
		wr(AB, 32'h4);
		rd(AB, 32'h0, "stop_idle");
		repeat (300) @(posedge clk);
		chk("pin_off", 32'(idle > 16'h00FA && pin === 1'h0), 32'h1);
		wr(AC, 32'h1);
		for (int f = 0; f < 8; f++)
			for (int d = 0; d < 8; d += 7)
			begin
				s = (f > 3) ? 8 : 4;
				wr(AF, 32'(f));
				wr(AD, 32'(d));
				repeat (800) @(posedge clk);
				chk("period", 32'(per), 32'((16 + 4 * (f % 4)) * s));
				chk("high", 32'(hi), 32'(((f % 4 > 1) ? 12 - d : 8 - d) * s));
			end
		wr(AF, 32'h0);
		wr(AD, 32'h5);
		wr(AC, 32'h0);
		wr(AC, 32'h3);
		repeat (300) @(posedge clk);
		chk("env_start", 32'(hi), 32'h20);
		for (n = 0; n < 20000 && hi == 16'h0020; n++) @(posedge clk);
		chk("env_wait", 32'(n < 17000), 32'h1);
		repeat (200) @(posedge clk);
		chk("env_step", 32'(hi), 32'h1C);
		wr(AC, 32'h7);
		repeat (300) @(posedge clk);
		chk("env_restart", 32'(hi), 32'h20);
		rd(AC, 32'h3, "ctrl_restart");
		wr(AB, 32'h2);
		rd(AB, 32'h0, "trig_blocked");
		wr(AC, 32'h2);
		wr(AD, 32'h3);
		burst(32'h0, 0, 32'h0, 8192);
		burst(32'h0, 3700, 32'h2, 12288);
		burst(32'h1, 2700, 32'h5, 3072);
		summarize();
	end
endmodule : tb_top
`default_nettype wire
